// ---- bmd_matrix.sv ----
// Six by six bus matrix with first-level decode, remap and SRAM split.
//
// Summary of operation
// - six masters run concurrently to free slaves
// - one identical decoder per master
// - masters indexed DMA, USB, display, transfer, processor
// - six slaves, each with its own arbiter
// - slaves indexed ROM, SRAM, display, USB, external, bridge
// - reach table limits which master sees which slave
// - paths outside the reach table are refused
// - peripheral transfer controller is one master port
// - general DMA is one master port, two channels
// - DMA chaining and write-back stay inside master
// - top four address bits pick one of sixteen banks
// - banks one to eight go to external port
// - bank zero holds 1 Mbyte internal regions
// - bank fifteen goes to the peripheral bridge
// - unused regions answer with an error
// - remap bit and boot pin choose address zero
// - SRAM is four 16 Kbyte blocks
// - SRAM at its own base, at zero after remap
// - instruction coupled area at 0x0010_0000
// - data coupled area at 0x0020_0000
// - AHB area at zero only for processor ports
// - split of SRAM set in 16 Kbyte steps
// - reset gives every block to the AHB area
// - ROM always at 0x0040_0000
`timescale 1ns/10ps
`default_nettype none

module bmd_matrix #(
	parameter int NM = bmd_pkg::NUM_MASTERS,
	parameter int NS = bmd_pkg::NUM_SLAVES
) (
	input  wire logic                            ref_clk,
	input  wire logic                            rst_b,
	input  wire bmd_pkg::bmd_mreq_t [NM-1:0]     mreq,
	output bmd_pkg::bmd_mrsp_t [NM-1:0]          mrsp,
	output bmd_pkg::bmd_sreq_t [NS-1:0]          sreq,
	input  wire bmd_pkg::bmd_srsp_t [NS-1:0]     srsp,
	input  wire bmd_pkg::bmd_arb_mode_t [NS-1:0] arb_mode,
	input  wire logic [NM-1:0]                   per_master_remap_bit,
	input  wire logic                            boot_memory_select_pin,
	input  wire logic [bmd_pkg::SPLIT_W-1:0]     itcm_blocks,
	input  wire logic [bmd_pkg::SPLIT_W-1:0]     dtcm_blocks,
	input  wire logic                            split_load
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int SW = bmd_pkg::SPLIT_W;
	localparam int IDX_W = bmd_pkg::IDX_W;

	bmd_pkg::bmd_mrsp_t [NM-1:0]        rsp_q;
	bmd_pkg::bmd_dec_t  [NM-1:0]        dec;
	logic [NM-1:0]                      active;
	logic [NS-1:0][NM-1:0]              slv_req;
	wire  logic [NS-1:0][NM-1:0]        grant;
	logic [NM-1:0]                      remap_q;
	logic                               boot_q;
	logic                               boot_seen_q;
	logic [SW-1:0]                      itcm_q;
	logic [SW-1:0]                      dtcm_q;

	// ----------------------------------------------------------------
	// SRAM block allocation
	// ----------------------------------------------------------------
	function automatic logic in_group(input int b, input int top,
		input logic [SW-1:0] n);
		return (b <= top) && (b > top - 2) && ((top - b) < int'(n));
	endfunction

	// Returns {ok, block}; free blocks fill the AHB area top down
	function automatic logic [2:0] sram_block(
		input bmd_pkg::bmd_area_t area,
		input logic [bmd_pkg::BLK_IDX_W-1:0] idx,
		input logic [SW-1:0] ni, input logic [SW-1:0] nd);
		logic       ok;
		logic [1:0] blk;
		int         cnt;
		ok = 1'b0;
		blk = 2'h0;
		cnt = 0;
		unique case (area)
			bmd_pkg::AREA_ITCM: begin
				ok = int'(idx) < int'(ni);
				blk = 2'(bmd_pkg::ITCM_TOP_BLK - int'(idx));
			end
			bmd_pkg::AREA_DTCM: begin
				ok = int'(idx) < int'(nd);
				blk = 2'(bmd_pkg::DTCM_TOP_BLK - int'(idx));
			end
			default: begin
				for (int b = bmd_pkg::SRAM_BLOCKS - 1; b >= 0; b--) begin
					if (!in_group(b, bmd_pkg::ITCM_TOP_BLK, ni) &&
					    !in_group(b, bmd_pkg::DTCM_TOP_BLK, nd)) begin
						if (cnt == int'(idx) && !ok) begin
							ok = 1'b1;
							blk = 2'(b);
						end
						cnt++;
					end
				end
			end
		endcase
		return {ok, blk};
	endfunction

	function automatic bmd_pkg::bmd_dec_t sram_hit(
		input bmd_pkg::bmd_area_t area, input logic [31:0] a,
		input logic [SW-1:0] ni, input logic [SW-1:0] nd);
		bmd_pkg::bmd_dec_t d;
		logic [2:0]        r;
		r = sram_block(area,
			a[bmd_pkg::OFS_MSB:bmd_pkg::BLK_OFS_W], ni, nd);
		d.hit = r[2];
		d.slave = bmd_pkg::SLV_SRAM;
		d.addr = {16'h0000, r[1:0], a[bmd_pkg::BLK_OFS_W-1:0]};
		return d;
	endfunction

	// ----------------------------------------------------------------
	// Address decoder, shared by every master
	// ----------------------------------------------------------------
	function automatic bmd_pkg::bmd_dec_t decode(input int m,
		input logic [31:0] a, input logic rmp, input logic boot,
		input logic [SW-1:0] ni, input logic [SW-1:0] nd);
		bmd_pkg::bmd_dec_t d;
		logic [3:0]        bank;
		logic [7:0]        rgn;
		logic              cpu;
		logic              rom_ok;
		bank = a[bmd_pkg::BANK_MSB:bmd_pkg::BANK_LSB];
		rgn = a[bmd_pkg::RGN_MSB:bmd_pkg::RGN_LSB];
		cpu = (m == int'(bmd_pkg::MST_INSTR)) ||
		      (m == int'(bmd_pkg::MST_DATA));
		rom_ok = a[bmd_pkg::OFS_MSB:bmd_pkg::ROM_OFS_W] == '0;
		d.hit = 1'b0;
		d.slave = bmd_pkg::SLV_ROM;
		d.addr = a;
		if (bank == bmd_pkg::BANK_PERIPH) begin
			d.hit = 1'b1;
			d.slave = bmd_pkg::SLV_BRIDGE;
		end else if (bank >= bmd_pkg::BANK_EXT_FIRST &&
		             bank <= bmd_pkg::BANK_EXT_LAST) begin
			d.hit = 1'b1;
			d.slave = bmd_pkg::SLV_EXTMEM;
		end else if (bank == bmd_pkg::BANK_INTERNAL) begin
			d.addr = {12'h000, a[bmd_pkg::OFS_MSB:0]};
			unique case (rgn)
				bmd_pkg::RGN_BOOT: begin
					if (rmp) begin
						// Other masters get no alias at zero
						if (cpu)
							d = sram_hit(bmd_pkg::AREA_AHB, a, ni, nd);
					end else if (boot) begin
						d.hit = rom_ok;
						d.slave = bmd_pkg::SLV_ROM;
					end else begin
						d.hit = 1'b1;
						d.slave = bmd_pkg::SLV_EXTMEM;
						d.addr = bmd_pkg::EXT_CS0_BASE |
						         {12'h000, a[bmd_pkg::OFS_MSB:0]};
					end
				end
				bmd_pkg::RGN_ITCM:
					d = sram_hit(bmd_pkg::AREA_ITCM, a, ni, nd);
				bmd_pkg::RGN_DTCM:
					d = sram_hit(bmd_pkg::AREA_DTCM, a, ni, nd);
				bmd_pkg::RGN_SRAMC:
					d = sram_hit(bmd_pkg::AREA_AHB, a, ni, nd);
				bmd_pkg::RGN_ROM: begin
					d.hit = rom_ok;
					d.slave = bmd_pkg::SLV_ROM;
				end
				bmd_pkg::RGN_DISP: begin
					d.hit = 1'b1;
					d.slave = bmd_pkg::SLV_DISP;
				end
				bmd_pkg::RGN_USB: begin
					d.hit = 1'b1;
					d.slave = bmd_pkg::SLV_USBRAM;
				end
				default: d.hit = 1'b0;
			endcase
		end
		if (!bmd_pkg::REACH[d.slave][m])
			d.hit = 1'b0;
		return d;
	endfunction

	// ----------------------------------------------------------------
	// Configuration capture
	// ----------------------------------------------------------------
	// Boot pin is taken on the first edge after release, never in reset
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			boot_q <= 1'b0;
			boot_seen_q <= 1'b0;
		end else if (!boot_seen_q) begin
			boot_q <= boot_memory_select_pin;
			boot_seen_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			remap_q <= '0;
		else
			remap_q <= per_master_remap_bit;
	end

	// Oversized requests clamp, since only two blocks per side exist
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			itcm_q <= bmd_pkg::SPLIT_RESET;
			dtcm_q <= bmd_pkg::SPLIT_RESET;
		end else if (split_load) begin
			itcm_q <= (itcm_blocks > bmd_pkg::SPLIT_MAX) ?
			          bmd_pkg::SPLIT_MAX : itcm_blocks;
			dtcm_q <= (dtcm_blocks > bmd_pkg::SPLIT_MAX) ?
			          bmd_pkg::SPLIT_MAX : dtcm_blocks;
		end
	end

	// ----------------------------------------------------------------
	// Per-master decode and slave requests
	// ----------------------------------------------------------------
	// Masters 0 and 3 front their own channels as one port each
	always_comb begin
		slv_req = '0;
		for (int m = 0; m < NM; m++) begin
			// Answer cycle masks the still-held request
			active[m] = mreq[m].valid && !rsp_q[m].done;
			dec[m] = decode(m, mreq[m].addr, remap_q[m], boot_q,
			                itcm_q, dtcm_q);
			if (active[m] && dec[m].hit)
				slv_req[dec[m].slave][m] = 1'b1;
		end
	end

	for (genvar s = 0; s < NS; s++) begin : g_arb
		bmd_slave_arbiter #(
			.N (NM)
		) u_arb (
			.ref_clk (ref_clk),
			.rst_b   (rst_b),
			.mode    (arb_mode[s]),
			.req     (slv_req[s]),
			.ack     (srsp[s].ack),
			.grant   (grant[s])
		);
	end

	always_comb begin
		sreq = '0;
		for (int s = 0; s < NS; s++)
			for (int m = 0; m < NM; m++)
				if (grant[s][m]) begin
					sreq[s].valid = 1'b1;
					sreq[s].write = mreq[m].write;
					sreq[s].addr = dec[m].addr;
					sreq[s].wdata = mreq[m].wdata;
					sreq[s].master = IDX_W'(m);
				end
	end

	// ----------------------------------------------------------------
	// Answers to masters
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			rsp_q <= '0;
		else
			for (int m = 0; m < NM; m++) begin
				rsp_q[m].done <= active[m] && (!dec[m].hit ||
					(grant[dec[m].slave][m] && srsp[dec[m].slave].ack));
				rsp_q[m].err <= active[m] && !dec[m].hit;
				rsp_q[m].rdata <= dec[m].hit ?
				                  srsp[dec[m].slave].rdata : '0;
			end
	end

	assign mrsp = rsp_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_unused_abort: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(active[0] && mreq[0].addr[31:28] > bmd_pkg::BANK_EXT_LAST &&
		 mreq[0].addr[31:28] < bmd_pkg::BANK_PERIPH)
		|=> (mrsp[0].done && mrsp[0].err))
		else $error("unused bank not aborted");

	a_bridge_bank: assert property (@(posedge ref_clk) disable iff (!rst_b)
		sreq[bmd_pkg::SLV_BRIDGE].valid |->
		(sreq[bmd_pkg::SLV_BRIDGE].addr[31:28] == bmd_pkg::BANK_PERIPH &&
		 sreq[bmd_pkg::SLV_BRIDGE].master < bmd_pkg::MST_PERXFR))
		else $error("bridge reached from wrong bank or master");

	a_ext_banks: assert property (@(posedge ref_clk) disable iff (!rst_b)
		sreq[bmd_pkg::SLV_EXTMEM].valid |->
		(sreq[bmd_pkg::SLV_EXTMEM].addr[31:28] >= bmd_pkg::BANK_EXT_FIRST &&
		 sreq[bmd_pkg::SLV_EXTMEM].addr[31:28] <= bmd_pkg::BANK_EXT_LAST))
		else $error("external port got address outside its banks");

	a_disp_path: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(sreq[bmd_pkg::SLV_DISP].valid || sreq[bmd_pkg::SLV_USBRAM].valid)
		|-> ((!sreq[bmd_pkg::SLV_DISP].valid ||
		      sreq[bmd_pkg::SLV_DISP].master >= bmd_pkg::MST_INSTR) &&
		     (!sreq[bmd_pkg::SLV_USBRAM].valid ||
		      sreq[bmd_pkg::SLV_USBRAM].master >= bmd_pkg::MST_INSTR)))
		else $error("display or USB RAM reached by a DMA master");

	a_rom_fixed: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(mreq[5].addr[31:15] == 17'h00080) |->
		(dec[5].hit && dec[5].slave == bmd_pkg::SLV_ROM))
		else $error("ROM base not decoded to ROM");

	a_boot_rom: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!remap_q[0] && mreq[0].addr[31:15] == 17'h00000) |->
		(dec[0].hit && dec[0].slave ==
		 (boot_q ? bmd_pkg::SLV_ROM : bmd_pkg::SLV_EXTMEM)))
		else $error("boot alias does not follow boot pin");

	a_remap_sram: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(remap_q[4] && !$past(split_load) &&
		 !(itcm_q == bmd_pkg::SPLIT_MAX && dtcm_q == bmd_pkg::SPLIT_MAX) &&
		 mreq[4].addr[31:14] == 18'h00000)
		|-> (dec[4].hit && dec[4].slave == bmd_pkg::SLV_SRAM))
		else $error("remapped zero not decoded to SRAM");

	a_split_reset: assert property (@(posedge ref_clk)
		(rst_b && !$past(rst_b)) |->
		(itcm_q == bmd_pkg::SPLIT_RESET && dtcm_q == bmd_pkg::SPLIT_RESET))
		else $error("SRAM split not all AHB after reset");

endmodule // bmd_matrix

`default_nettype wire

// ---- bmd_pkg.sv ----
// Shared constants and carrier types for the bus matrix decoder.
package bmd_pkg;

	// ----------------------------------------------------------------
	// Matrix size and bus widths
	// ----------------------------------------------------------------
	localparam int NUM_MASTERS = 6;
	localparam int NUM_SLAVES  = 6;
	localparam int ADDR_W      = 32;
	localparam int DATA_W      = 32;
	localparam int IDX_W       = 3;

	// ----------------------------------------------------------------
	// Master and slave indices
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] MST_DMA    = 3'h0;
	localparam logic [IDX_W-1:0] MST_USB    = 3'h1;
	localparam logic [IDX_W-1:0] MST_DISP   = 3'h2;
	localparam logic [IDX_W-1:0] MST_PERXFR = 3'h3;
	localparam logic [IDX_W-1:0] MST_INSTR  = 3'h4;
	localparam logic [IDX_W-1:0] MST_DATA   = 3'h5;

	localparam logic [IDX_W-1:0] SLV_ROM    = 3'h0;
	localparam logic [IDX_W-1:0] SLV_SRAM   = 3'h1;
	localparam logic [IDX_W-1:0] SLV_DISP   = 3'h2;
	localparam logic [IDX_W-1:0] SLV_USBRAM = 3'h3;
	localparam logic [IDX_W-1:0] SLV_EXTMEM = 3'h4;
	localparam logic [IDX_W-1:0] SLV_BRIDGE = 3'h5;

	// Reach table, indexed [slave][master]
	localparam logic [NUM_SLAVES-1:0][NUM_MASTERS-1:0] REACH = {
		6'h07,  // Peripheral bridge: masters 0..2
		6'h3F,  // External memory port: all
		6'h30,  // USB RAM: processor ports only
		6'h30,  // Display registers: processor ports only
		6'h3F,  // SRAM: all
		6'h3B   // ROM: all but display DMA
	};

	// ----------------------------------------------------------------
	// First and second level address fields
	// ----------------------------------------------------------------
	localparam int BANK_MSB = 31;
	localparam int BANK_LSB = 28;
	localparam int RGN_MSB  = 27;
	localparam int RGN_LSB  = 20;
	localparam int OFS_MSB  = 19;

	localparam logic [3:0] BANK_INTERNAL = 4'h0;
	localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
	localparam logic [3:0] BANK_EXT_LAST  = 4'h8;
	localparam logic [3:0] BANK_PERIPH    = 4'hF;

	localparam logic [7:0] RGN_BOOT  = 8'h00;
	localparam logic [7:0] RGN_ITCM  = 8'h01;
	localparam logic [7:0] RGN_DTCM  = 8'h02;
	localparam logic [7:0] RGN_SRAMC = 8'h03;
	localparam logic [7:0] RGN_ROM   = 8'h04;
	localparam logic [7:0] RGN_DISP  = 8'h05;
	localparam logic [7:0] RGN_USB   = 8'h06;

	localparam logic [ADDR_W-1:0] EXT_CS0_BASE = 32'h1000_0000;

	// ----------------------------------------------------------------
	// Internal memories
	// ----------------------------------------------------------------
	localparam int ROM_OFS_W    = 15;
	localparam int SRAM_BLOCKS  = 4;
	localparam int BLK_OFS_W    = 14;
	localparam int BLK_IDX_W    = OFS_MSB - BLK_OFS_W + 1;
	localparam int SPLIT_W      = 2;
	localparam logic [SPLIT_W-1:0] SPLIT_MAX   = 2'h2;
	localparam logic [SPLIT_W-1:0] SPLIT_RESET = 2'h0;
	localparam int ITCM_TOP_BLK = 1;
	localparam int DTCM_TOP_BLK = 3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic {ARB_FIXED, ARB_ROUND} bmd_arb_mode_t;
	typedef enum logic [1:0] {AREA_ITCM, AREA_DTCM, AREA_AHB} bmd_area_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bmd_mreq_t;

	typedef struct packed {
		logic              done;
		logic              err;
		logic [DATA_W-1:0] rdata;
	} bmd_mrsp_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [IDX_W-1:0]  master;
	} bmd_sreq_t;

	typedef struct packed {
		logic              ack;
		logic [DATA_W-1:0] rdata;
	} bmd_srsp_t;

	typedef struct packed {
		logic              hit;
		logic [IDX_W-1:0]  slave;
		logic [ADDR_W-1:0] addr;
	} bmd_dec_t;

endpackage

// ---- bmd_slave_arbiter.sv ----
// Per-slave arbiter with fixed or round-robin choice and transfer lock.
`timescale 1ns/10ps
`default_nettype none

module bmd_slave_arbiter #(
	parameter int N = 6
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	input  wire bmd_pkg::bmd_arb_mode_t mode,
	input  wire logic [N-1:0]          req,
	input  wire logic                  ack,
	output logic [N-1:0]               grant
);

	localparam int LW = $clog2(N);

	typedef enum logic {ARB_OPEN, ARB_LOCKED} bmd_arb_state_t;

	bmd_arb_state_t state_q;
	logic [N-1:0]   grant_q;
	logic [LW-1:0]  last_q;

	function automatic logic [N-1:0] pick(input logic [N-1:0] r,
		input bmd_pkg::bmd_arb_mode_t md, input logic [LW-1:0] last);
		logic [N-1:0] g;
		int           start;
		int           k;
		g = '0;
		start = (md == bmd_pkg::ARB_ROUND) ? int'(last) + 1 : 0;
		for (int i = 0; i < N; i++) begin
			k = (start + i) % N;
			if (g == '0 && r[k])
				g[k] = 1'b1;
		end
		return g;
	endfunction

	function automatic logic [LW-1:0] to_idx(input logic [N-1:0] g);
		logic [LW-1:0] x;
		x = '0;
		for (int i = 0; i < N; i++)
			if (g[i])
				x = LW'(i);
		return x;
	endfunction

	// A slave that stretches its answer keeps its master
	assign grant = (state_q == ARB_LOCKED) ? grant_q
	                                       : pick(req, mode, last_q);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ARB_OPEN;
			grant_q <= '0;
		end else begin
			unique case (state_q)
				ARB_OPEN: begin
					if (grant != '0 && !ack) begin
						state_q <= ARB_LOCKED;
						grant_q <= grant;
					end
				end
				ARB_LOCKED: begin
					if (ack)
						state_q <= ARB_OPEN;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			last_q <= '0;
		else if (ack && grant != '0)
			last_q <= to_idx(grant);
	end

	a_grant_onehot: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$onehot0(grant) && ((grant & ~req) == '0))
		else $error("slave grant not one-hot or not requested");

	a_grant_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(grant != '0 && !ack) |=> (grant == $past(grant)))
		else $error("grant changed before slave answered");

endmodule // bmd_slave_arbiter

`default_nettype wire

// ---- bmd_slave_model.sv ----
// Slave-side model: six memory slaves with an adjustable wait.
`timescale 1ns/10ps
`default_nettype none

module bmd_slave_model (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	input  wire logic [1:0]               ack_wait,
	input  wire bmd_pkg::bmd_sreq_t [5:0] sreq,
	output bmd_pkg::bmd_srsp_t [5:0]      srsp
);
	logic [1:0] cnt_q [6];

	always @(posedge ref_clk or negedge rst_b) begin
		for (int s = 0; s < 6; s++) begin
			if (!rst_b || !sreq[s].valid || srsp[s].ack)
				cnt_q[s] <= 2'h0;
			else
				cnt_q[s] <= cnt_q[s] + 2'h1;
		end
	end

	// Data shows write bit, slave index and address, folded with wdata
	// Inverted outside an ack, so a stale read never matches
	always_comb begin
		for (int s = 0; s < 6; s++) begin
			srsp[s].ack   = sreq[s].valid && cnt_q[s] == ack_wait;
			srsp[s].rdata = {sreq[s].write, 3'(s), sreq[s].addr[27:0]} ^
			                sreq[s].wdata;
			if (!srsp[s].ack)
				srsp[s].rdata = ~srsp[s].rdata;
		end
	end
endmodule // bmd_slave_model

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the bus matrix decoder.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic                         ref_clk;
	logic                         rst_b;
	logic                         boot;
	logic                         split_load;
	bmd_pkg::bmd_mreq_t [5:0]     mreq;
	bmd_pkg::bmd_mrsp_t [5:0]     mrsp;
	bmd_pkg::bmd_sreq_t [5:0]     sreq;
	bmd_pkg::bmd_srsp_t [5:0]     srsp;
	bmd_pkg::bmd_arb_mode_t [5:0] arb_mode;
	logic [5:0]                   remap;
	logic [1:0]                   itcm;
	logic [1:0]                   dtcm;
	logic [1:0]                   ack_wait;
	int                           failures;
	int                           comparisons;
	time                          t_done [6];

	bmd_matrix bmd_matrix_inst (
		.ref_clk(ref_clk), .rst_b(rst_b), .mreq(mreq), .mrsp(mrsp),
		.sreq(sreq), .srsp(srsp), .arb_mode(arb_mode),
		.per_master_remap_bit(remap), .boot_memory_select_pin(boot),
		.itcm_blocks(itcm), .dtcm_blocks(dtcm), .split_load(split_load)
	);

	bmd_slave_model bmd_slave_model_inst (
		.ref_clk(ref_clk), .rst_b(rst_b), .ack_wait(ack_wait),
		.sreq(sreq), .srsp(srsp)
	);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// ------------
	// Shared tasks
	// ------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic do_reset(input logic b);
		rst_b = 1'b0;
		remap = 6'h00;
		mreq = '0;
		boot = b;
		repeat (20) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	// One word transfer, held until done, then judged
	task automatic xfer(input int m, input logic [31:0] a, input logic e,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		#1;
		mreq[m] = '{valid: 1'b1, write: 1'b0, addr: a, wdata: 32'h0};
		n = 0;
		while (mrsp[m].done !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		t_done[m] = $time;
		check({31'h0, mrsp[m].done}, 32'h1);
		check({31'h0, mrsp[m].err}, {31'h0, e});
		check(mrsp[m].rdata, e ? 32'h0 : d);
		mreq[m].valid = 1'b0;
	endtask

	// ---------
	// Scenarios
	// ---------
	task automatic t_decode();
		logic [31:0] adr [8] = '{32'h0040_0010, 32'h0030_0010,
			32'h0050_0010, 32'h0060_0010, 32'h8000_0010, 32'hF000_0010,
			32'h9000_0010, 32'h0070_0010};
		logic [27:0] phy [6] = '{28'h10, 28'hC010, 28'h10, 28'h10,
			28'h10, 28'h10};
		logic [5:0] reach [6] = '{6'h3B, 6'h3F, 6'h30, 6'h30, 6'h3F, 6'h07};
		for (int m = 0; m < 6; m++) begin
			xfer(m, 32'h1000_0010, 1'b0, {4'h4, 28'h10});
			for (int i = 0; i < 8; i++) begin
				if (i > 5)
					xfer(m, adr[i], 1'b1, 32'h0);
				else
					xfer(m, adr[i], !reach[i][m], {1'b0, 3'(i), phy[i]});
			end
		end
	endtask

	task automatic t_boot();
		do_reset(1'b1);
		xfer(0, 32'h10, 1'b0, {4'h0, 28'h10});
		remap = 6'h11;
		@(posedge ref_clk);
		xfer(4, 32'h10, 1'b0, {4'h1, 28'hC010});
		xfer(0, 32'h10, 1'b1, 32'h0);
		xfer(0, 32'h0040_0010, 1'b0, {4'h0, 28'h10});
		xfer(4, 32'h0030_0010, 1'b0, {4'h1, 28'hC010});
		do_reset(1'b0);
		xfer(3, 32'h10, 1'b0, {4'h4, 28'h10});
		xfer(5, 32'h0040_0010, 1'b0, {4'h0, 28'h10});
	endtask

	task automatic t_split();
		itcm = 2'h2;
		dtcm = 2'h1;
		split_load = 1'b1;
		@(posedge ref_clk);
		#1 split_load = 1'b0;
		xfer(5, 32'h0010_0010, 1'b0, {4'h1, 28'h4010});
		xfer(0, 32'h0010_4010, 1'b0, {4'h1, 28'h0010});
		xfer(1, 32'h0020_0010, 1'b0, {4'h1, 28'hC010});
		xfer(5, 32'h0020_4010, 1'b1, 32'h0);
		xfer(0, 32'h0030_0010, 1'b0, {4'h1, 28'h8010});
		xfer(0, 32'h0030_4010, 1'b1, 32'h0);
		do_reset(1'b1);
		xfer(2, 32'h0030_C010, 1'b0, {4'h1, 28'h0010});
	endtask

	// Contention on SRAM, then two slaves served together
	task automatic t_arb();
		ack_wait = 2'h2;
		fork
			xfer(0, 32'h0030_0010, 1'b0, {4'h1, 28'hC010});
			xfer(5, 32'h0030_0010, 1'b0, {4'h1, 28'hC010});
		join
		check({31'h0, t_done[0] < t_done[5]}, 32'h1);
		arb_mode[1] = bmd_pkg::ARB_ROUND;
		xfer(0, 32'h0030_0010, 1'b0, {4'h1, 28'hC010});
		fork
			xfer(0, 32'h0030_0010, 1'b0, {4'h1, 28'hC010});
			xfer(5, 32'h0030_0010, 1'b0, {4'h1, 28'hC010});
		join
		check({31'h0, t_done[5] < t_done[0]}, 32'h1);
		ack_wait = 2'h0;
		fork
			xfer(0, 32'h1000_0010, 1'b0, {4'h4, 28'h10});
			xfer(4, 32'h0040_0010, 1'b0, {4'h0, 28'h10});
		join
		check({31'h0, t_done[0] == t_done[4]}, 32'h1);
	endtask

	// Write path: write bit and data must reach the slave
	task automatic t_write();
		@(posedge ref_clk);
		#1;
		mreq[1] = '{valid: 1'b1, write: 1'b1, addr: 32'hF000_0020,
			wdata: 32'h0000_00FF};
		@(posedge ref_clk);
		#1;
		check({31'h0, mrsp[1].done}, 32'h1);
		check({31'h0, mrsp[1].err}, 32'h0);
		check(mrsp[1].rdata, 32'hD000_00DF);
		mreq[1].valid = 1'b0;
	endtask

	task automatic test_done();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		failures = 0;
		comparisons = 0;
		arb_mode = '{default: bmd_pkg::ARB_FIXED};
		itcm = 2'h0;
		dtcm = 2'h0;
		split_load = 1'b0;
		ack_wait = 2'h0;
		do_reset(1'b1);
		t_decode();
		t_boot();
		t_split();
		t_arb();
		t_write();
		test_done();
	end

	// Whole run needs a few hundred cycles
	initial begin
		#200us;
		failures++;
		test_done();
	end
endmodule // tb_top

`default_nettype wire
